// *** src/xyds_pkg.sv ***
package xyds_pkg;

   // ************************************************************
   // Widths and address space
   // ************************************************************
   localparam int          ADDR_W       = 16;
   localparam int          DATA_W       = 16;
   localparam int          BE_W         = 2;
   localparam logic [15:0] Y_BASE_DFLT  = 16'h0800;
   localparam logic [15:0] RST_ADDR     = 16'h0000;
   localparam logic [15:0] RST_DATA     = 16'h0000;
   localparam logic [15:0] RST_PTR      = 16'h0000;

   // ************************************************************
   // Byte lanes
   // ************************************************************
   localparam logic [1:0]  BE_NONE      = 2'h0;
   localparam logic [1:0]  BE_LO        = 2'h1;
   localparam logic [1:0]  BE_HI        = 2'h2;
   localparam logic [1:0]  BE_WORD      = 2'h3;
   localparam int          BYTE_SEL_BIT = 0;
   localparam int          SIGN_BIT     = 15;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int          RD_LATENCY   = 2;

   // ************************************************************
   // Modes and instruction classes
   // ************************************************************
   typedef enum logic [1:0] {
      mode_linear = 2'b00,
      mode_modulo = 2'b01,
      mode_bitrev = 2'b10
   } xyds_mode_t;

   typedef enum logic [3:0] {
      op_general                       = 4'b0000,
      accumulator_clear_op             = 4'b0001,
      euclidean_distance_op            = 4'b0010,
      euclidean_distance_accumulate_op = 4'b0011,
      mac_op                           = 4'b0100,
      prefetch_store_accumulator_op    = 4'b0101,
      multiply_op                      = 4'b0110,
      multiply_negate_op               = 4'b0111,
      multiply_subtract_op             = 4'b1000
   } xyds_op_t;

endpackage : xyds_pkg

// *** src/xyds_agen_if.sv ***
interface xyds_agen_if;
   logic               [15:0] ptr;
   logic               [15:0] step;
   xyds_pkg::xyds_mode_t      mode;
   logic                      word;
   logic                      write;
   logic               [15:0] mod_start;
   logic               [15:0] mod_end;
   logic               [15:0] rev_mod;
   logic               [15:0] ea;
   logic               [15:0] next_ptr;

   modport agen (
      input  ptr, step, mode, word, write, mod_start, mod_end, rev_mod,
      output ea, next_ptr
   );

   modport user (
      output ptr, step, mode, word, write, mod_start, mod_end, rev_mod,
      input  ea, next_ptr
   );
endinterface : xyds_agen_if

// *** src/xyds_agen.sv ***
module xyds_agen #(
   parameter bit ALLOW_REV = 1'b0
) (
   xyds_agen_if.agen ag
);

   // ************************************************************
   // Bit reversal helper
   // ************************************************************
   function automatic logic [15:0] xyds_rev(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15 - i];
      end
      return r;
   endfunction : xyds_rev

   localparam xyds_pkg::xyds_mode_t mode_modulo_c = xyds_pkg::mode_modulo;
   localparam xyds_pkg::xyds_mode_t mode_bitrev_c = xyds_pkg::mode_bitrev;

   logic [15:0] sum;
   logic [15:0] len;

   always_comb begin
      sum = ag.ptr + ag.step;
      len = 16'(ag.mod_end - ag.mod_start + 16'h0001);
      // Word accesses ignore the byte select bit.
      ag.ea = ag.word ? {ag.ptr[15:1], 1'b0} : ag.ptr;
      ag.next_ptr = sum;
      case (ag.mode)
         mode_modulo_c: begin
            if (!ag.step[xyds_pkg::SIGN_BIT] && (sum > ag.mod_end)) begin
               ag.next_ptr = 16'(sum - len);
            end else if (ag.step[xyds_pkg::SIGN_BIT] && (sum < ag.mod_start)) begin
               ag.next_ptr = 16'(sum + len);
            end
         end
         mode_bitrev_c: begin
            // Reverse-carry stepping; any other use falls back to linear stepping.
            if (ALLOW_REV && ag.write) begin
               ag.next_ptr = xyds_rev(16'(xyds_rev(ag.ptr) + xyds_rev(ag.rev_mod)));
            end
         end
         default: begin
            ag.next_ptr = sum;
         end
      endcase
   end

endmodule : xyds_agen

// *** src/xyds_top.sv ***
module xyds_top #(
   parameter logic [15:0] Y_BASE = xyds_pkg::Y_BASE_DFLT
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // Instruction class and shared addressing setup
   input  wire xyds_pkg::xyds_op_t   op,
   input  wire logic          [15:0] x_mod_start,
   input  wire logic          [15:0] x_mod_end,
   input  wire logic          [15:0] y_mod_start,
   input  wire logic          [15:0] y_mod_end,
   input  wire logic          [15:0] x_rev_mod,
   // X read request
   input  wire logic                 x_rd_req,
   input  wire logic          [15:0] x_rd_ptr,
   input  wire logic          [15:0] x_rd_step,
   input  wire xyds_pkg::xyds_mode_t x_rd_mode,
   input  wire logic                 x_rd_word,
   // X write request
   input  wire logic                 x_wr_req,
   input  wire logic          [15:0] x_wr_ptr,
   input  wire logic          [15:0] x_wr_step,
   input  wire xyds_pkg::xyds_mode_t x_wr_mode,
   input  wire logic                 x_wr_word,
   input  wire logic          [15:0] x_wr_data,
   // Y read request
   input  wire logic                 y_rd_req,
   input  wire logic          [15:0] y_rd_ptr,
   input  wire logic          [15:0] y_rd_step,
   input  wire xyds_pkg::xyds_mode_t y_rd_mode,
   // Answers to the pipeline
   output logic                      x_rd_valid,
   output logic               [15:0] x_rd_data,
   output logic                      y_rd_valid,
   output logic               [15:0] y_rd_data,
   output logic               [15:0] x_rd_ptr_next,
   output logic               [15:0] x_wr_ptr_next,
   output logic               [15:0] y_rd_ptr_next,
   output logic                      y_range_err,
   // X RAM port
   output logic                      ram_x_rd_en,
   output logic               [15:0] ram_x_rd_addr,
   input  wire logic          [15:0] ram_x_rd_data,
   output logic                      ram_x_wr_en,
   output logic               [15:0] ram_x_wr_addr,
   output logic                [1:0] ram_x_wr_be,
   output logic               [15:0] ram_x_wr_data,
   // Y RAM port
   output logic                      ram_y_rd_en,
   output logic               [15:0] ram_y_rd_addr,
   input  wire logic          [15:0] ram_y_rd_data
);

   // ************************************************************
   // Address generators
   // ************************************************************
   xyds_agen_if xr_if ();
   xyds_agen_if xw_if ();
   xyds_agen_if yr_if ();

   xyds_agen #(.ALLOW_REV(1'b0)) u_x_rd_gen (.ag(xr_if));
   xyds_agen #(.ALLOW_REV(1'b1)) u_x_wr_gen (.ag(xw_if));
   xyds_agen #(.ALLOW_REV(1'b0)) u_y_rd_gen (.ag(yr_if));

   always_comb begin
      xr_if.ptr       = x_rd_ptr;
      xr_if.step      = x_rd_step;
      xr_if.mode      = x_rd_mode;
      xr_if.word      = x_rd_word;
      xr_if.write     = 1'b0;
      xr_if.mod_start = x_mod_start;
      xr_if.mod_end   = x_mod_end;
      xr_if.rev_mod   = x_rev_mod;
      xw_if.ptr       = x_wr_ptr;
      xw_if.step      = x_wr_step;
      xw_if.mode      = x_wr_mode;
      xw_if.word      = x_wr_word;
      xw_if.write     = 1'b1;
      xw_if.mod_start = x_mod_start;
      xw_if.mod_end   = x_mod_end;
      xw_if.rev_mod   = x_rev_mod;
      yr_if.ptr       = y_rd_ptr;
      yr_if.step      = y_rd_step;
      yr_if.mode      = y_rd_mode;
      yr_if.word      = 1'b1;
      yr_if.write     = 1'b0;
      yr_if.mod_start = y_mod_start;
      yr_if.mod_end   = y_mod_end;
      yr_if.rev_mod   = x_rev_mod;
   end

   // ************************************************************
   // Request issue to the RAM ports
   // ************************************************************
   logic        mac_class;
   logic        y_in_space;
   logic        y_go;
   logic        xr_en_reg,  xr_en_next;
   logic [15:0] xr_addr_reg, xr_addr_next;
   logic        xw_en_reg,  xw_en_next;
   logic [15:0] xw_addr_reg, xw_addr_next;
   logic  [1:0] xw_be_reg,  xw_be_next;
   logic [15:0] xw_data_reg, xw_data_next;
   logic        yr_en_reg,  yr_en_next;
   logic [15:0] yr_addr_reg, yr_addr_next;
   logic [15:0] xr_np_reg, xr_np_next;
   logic [15:0] xw_np_reg, xw_np_next;
   logic [15:0] yr_np_reg, yr_np_next;
   logic        yerr_reg, yerr_next;

   always_comb begin
      mac_class    = (op != xyds_pkg::op_general);
      y_in_space   = (yr_if.ea >= Y_BASE);
      y_go         = y_rd_req && mac_class && y_in_space;
      // The X read bus covers the whole 64 KB range, Y region included.
      xr_en_next   = x_rd_req;
      xr_addr_next = xr_if.ea;
      xr_np_next   = x_rd_req ? xr_if.next_ptr : xr_np_reg;
      // Writes always go to the combined space on the X write bus.
      xw_en_next   = x_wr_req;
      xw_addr_next = xw_if.ea;
      xw_np_next   = x_wr_req ? xw_if.next_ptr : xw_np_reg;
      xw_data_next = x_wr_req ? x_wr_data : xw_data_reg;
      if (!x_wr_req) begin
         xw_be_next = xyds_pkg::BE_NONE;
      end else if (x_wr_word) begin
         xw_be_next = xyds_pkg::BE_WORD;
      end else if (xw_if.ea[xyds_pkg::BYTE_SEL_BIT]) begin
         xw_be_next   = xyds_pkg::BE_HI;
         xw_data_next = {x_wr_data[7:0], x_wr_data[7:0]};
      end else begin
         xw_be_next   = xyds_pkg::BE_LO;
         xw_data_next = {x_wr_data[7:0], x_wr_data[7:0]};
      end
      yr_en_next   = y_go;
      yr_addr_next = yr_if.ea;
      yr_np_next   = y_go ? yr_if.next_ptr : yr_np_reg;
      // A MAC-class Y read below the fixed boundary is dropped and flagged for one cycle.
      yerr_next    = y_rd_req && mac_class && !y_in_space;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xr_en_reg   <= 1'b0;
         xr_addr_reg <= xyds_pkg::RST_ADDR;
         xw_en_reg   <= 1'b0;
         xw_addr_reg <= xyds_pkg::RST_ADDR;
         xw_be_reg   <= xyds_pkg::BE_NONE;
         xw_data_reg <= xyds_pkg::RST_DATA;
         yr_en_reg   <= 1'b0;
         yr_addr_reg <= xyds_pkg::RST_ADDR;
         xr_np_reg   <= xyds_pkg::RST_PTR;
         xw_np_reg   <= xyds_pkg::RST_PTR;
         yr_np_reg   <= xyds_pkg::RST_PTR;
         yerr_reg    <= 1'b0;
      end else begin
         xr_en_reg   <= xr_en_next;
         xr_addr_reg <= xr_addr_next;
         xw_en_reg   <= xw_en_next;
         xw_addr_reg <= xw_addr_next;
         xw_be_reg   <= xw_be_next;
         xw_data_reg <= xw_data_next;
         yr_en_reg   <= yr_en_next;
         yr_addr_reg <= yr_addr_next;
         xr_np_reg   <= xr_np_next;
         xw_np_reg   <= xw_np_next;
         yr_np_reg   <= yr_np_next;
         yerr_reg    <= yerr_next;
      end
   end

   // ************************************************************
   // Read return: RAM answers one cycle after its enable
   // ************************************************************
   logic        xr_pend_reg, xr_pend_next;
   logic        yr_pend_reg, yr_pend_next;
   logic        xv_reg, xv_next;
   logic        yv_reg, yv_next;
   logic [15:0] xd_reg, xd_next;
   logic [15:0] yd_reg, yd_next;

   always_comb begin
      xr_pend_next = xr_en_reg;
      yr_pend_next = yr_en_reg;
      xv_next      = xr_pend_reg;
      yv_next      = yr_pend_reg;
      xd_next      = xr_pend_reg ? ram_x_rd_data : xd_reg;
      yd_next      = yr_pend_reg ? ram_y_rd_data : yd_reg;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xr_pend_reg <= 1'b0;
         yr_pend_reg <= 1'b0;
         xv_reg      <= 1'b0;
         yv_reg      <= 1'b0;
         xd_reg      <= xyds_pkg::RST_DATA;
         yd_reg      <= xyds_pkg::RST_DATA;
      end else begin
         xr_pend_reg <= xr_pend_next;
         yr_pend_reg <= yr_pend_next;
         xv_reg      <= xv_next;
         yv_reg      <= yv_next;
         xd_reg      <= xd_next;
         yd_reg      <= yd_next;
      end
   end

   always_comb begin
      ram_x_rd_en   = xr_en_reg;
      ram_x_rd_addr = xr_addr_reg;
      ram_x_wr_en   = xw_en_reg;
      ram_x_wr_addr = xw_addr_reg;
      ram_x_wr_be   = xw_be_reg;
      ram_x_wr_data = xw_data_reg;
      ram_y_rd_en   = yr_en_reg;
      ram_y_rd_addr = yr_addr_reg;
      x_rd_valid    = xv_reg;
      x_rd_data     = xd_reg;
      y_rd_valid    = yv_reg;
      y_rd_data     = yd_reg;
      x_rd_ptr_next = xr_np_reg;
      x_wr_ptr_next = xw_np_reg;
      y_rd_ptr_next = yr_np_reg;
      y_range_err   = yerr_reg;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_x_issue;
      ram_x_rd_en;
   endsequence

   sequence s_x_return;
      ##(xyds_pkg::RD_LATENCY) x_rd_valid;
   endsequence

   AST_X_RD_ISSUE: assert property (x_rd_req |=> ram_x_rd_en && ram_x_rd_addr == $past(xr_if.ea))
      else $error("X read request not issued on the X read bus");
   AST_Y_ONLY_MAC: assert property (ram_y_rd_en |-> $past(y_rd_req && op != xyds_pkg::op_general))
      else $error("Y read issued for a non MAC-class instruction");
   AST_X_RD_LAT: assert property (s_x_issue |-> s_x_return)
      else $error("X read data not returned two cycles after issue");
   AST_DUAL_READ: assert property (x_rd_req && y_go |=> ram_x_rd_en && ram_y_rd_en)
      else $error("X and Y operand reads not issued together");
   AST_WORD_EVEN: assert property (ram_x_wr_en && ram_x_wr_be == xyds_pkg::BE_WORD |-> !ram_x_wr_addr[0])
      else $error("Word write at odd byte address");
   AST_BYTE_LANE: assert property (ram_x_wr_en && ram_x_wr_be != xyds_pkg::BE_WORD
                                   |-> ram_x_wr_be == (ram_x_wr_addr[0] ? xyds_pkg::BE_HI : xyds_pkg::BE_LO))
      else $error("Byte write lane does not match address bit 0");
   AST_NO_REV_READ: assert property (x_rd_req && x_rd_mode == xyds_pkg::mode_bitrev
                                     |=> x_rd_ptr_next == 16'($past(x_rd_ptr) + $past(x_rd_step)))
      else $error("Bit-reversed stepping applied to a read");
   AST_Y_RANGE: assert property (y_rd_req && mac_class && yr_if.ea < Y_BASE |=> y_range_err && !ram_y_rd_en)
      else $error("Y read below boundary not refused");
   AST_MOD_WRAP: assert property (x_rd_req && x_rd_mode == xyds_pkg::mode_modulo && x_mod_start <= x_mod_end
                                  && x_rd_ptr >= x_mod_start && x_rd_ptr <= x_mod_end
                                  && x_rd_step <= 16'(x_mod_end - x_mod_start)
                                  |=> x_rd_ptr_next >= $past(x_mod_start) && x_rd_ptr_next <= $past(x_mod_end))
      else $error("Modulo pointer left its buffer");
   AST_WR_INDEP: assert property (x_wr_req |=> ram_x_wr_en && ram_x_wr_addr == $past(xw_if.ea))
      else $error("Write not issued on the X write bus");

endmodule : xyds_top

// *** test/xyds_ram_model.sv ***
module xyds_ram_model (
   // Clock
   input  wire logic        clk,
   // X side
   input  wire logic        x_rd_en,
   input  wire logic [15:0] x_rd_addr,
   output logic      [15:0] x_rd_data,
   input  wire logic        x_wr_en,
   input  wire logic [15:0] x_wr_addr,
   input  wire logic  [1:0] x_wr_be,
   input  wire logic [15:0] x_wr_data,
   // Y side
   input  wire logic        y_rd_en,
   input  wire logic [15:0] y_rd_addr,
   output logic      [15:0] y_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // One combined array behind both read ports
   // ************************************************************
   logic [15:0] mem [0:32767];

   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 16'(i) ^ 16'hA55A;
      end
      x_rd_data = 16'h0000;
      y_rd_data = 16'h0000;
   end

   // Idle read lines flip every cycle, so a late sample never matches by luck.
   always @(posedge clk) begin
      x_rd_data <= x_rd_en ? mem[x_rd_addr[15:1]] : ~x_rd_data;
      y_rd_data <= y_rd_en ? mem[y_rd_addr[15:1]] : ~y_rd_data;
      if (x_wr_en && x_wr_be[0]) begin
         mem[x_wr_addr[15:1]][7:0] <= x_wr_data[7:0];
      end
      if (x_wr_en && x_wr_be[1]) begin
         mem[x_wr_addr[15:1]][15:8] <= x_wr_data[15:8];
      end
   end
endmodule : xyds_ram_model

// *** test/test_xyds_top.sv ***
module test_xyds_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [15:0] YB = xyds_pkg::Y_BASE_DFLT;
   logic                 clk, rst_b, x_rd_req, x_rd_word, x_wr_req, x_wr_word, y_rd_req;
   logic          [15:0] x_mod_start, x_mod_end, y_mod_start, y_mod_end, x_rev_mod;
   logic          [15:0] x_rd_ptr, x_rd_step, x_wr_ptr, x_wr_step, x_wr_data, y_rd_ptr, y_rd_step;
   xyds_pkg::xyds_op_t   op;
   xyds_pkg::xyds_mode_t x_rd_mode, x_wr_mode, y_rd_mode;
   logic                 x_rd_valid, y_rd_valid, y_range_err, ram_x_rd_en, ram_x_wr_en, ram_y_rd_en;
   logic          [15:0] x_rd_data, y_rd_data, x_rd_ptr_next, x_wr_ptr_next, y_rd_ptr_next;
   logic          [15:0] ram_x_rd_addr, ram_x_rd_data, ram_x_wr_addr, ram_x_wr_data;
   logic          [15:0] ram_y_rd_addr, ram_y_rd_data;
   logic           [1:0] ram_x_wr_be;
   logic          [15:0] shadow [logic [14:0]];
   int                   fail_count, tests_run, cycles;

   xyds_top DUT (.clk, .rst_b, .op, .x_mod_start, .x_mod_end, .y_mod_start, .y_mod_end, .x_rev_mod,
      .x_rd_req, .x_rd_ptr, .x_rd_step, .x_rd_mode, .x_rd_word, .x_wr_req, .x_wr_ptr, .x_wr_step,
      .x_wr_mode, .x_wr_word, .x_wr_data, .y_rd_req, .y_rd_ptr, .y_rd_step, .y_rd_mode,
      .x_rd_valid, .x_rd_data, .y_rd_valid, .y_rd_data, .x_rd_ptr_next, .x_wr_ptr_next,
      .y_rd_ptr_next, .y_range_err, .ram_x_rd_en, .ram_x_rd_addr, .ram_x_rd_data, .ram_x_wr_en,
      .ram_x_wr_addr, .ram_x_wr_be, .ram_x_wr_data, .ram_y_rd_en, .ram_y_rd_addr, .ram_y_rd_data);

   xyds_ram_model ram (.clk, .x_rd_en(ram_x_rd_en), .x_rd_addr(ram_x_rd_addr),
      .x_rd_data(ram_x_rd_data), .x_wr_en(ram_x_wr_en), .x_wr_addr(ram_x_wr_addr),
      .x_wr_be(ram_x_wr_be), .x_wr_data(ram_x_wr_data), .y_rd_en(ram_y_rd_en),
      .y_rd_addr(ram_y_rd_addr), .y_rd_data(ram_y_rd_data));

   always #12.5 clk = ~clk;

   // ************************************************************
   // Expectations
   // ************************************************************
   function automatic logic [15:0] rev16(input logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         rev16[i] = v[15 - i];
      end
   endfunction : rev16

   function automatic logic [15:0] next_ptr(input logic [15:0] p, s, ms, me,
                                            input xyds_pkg::xyds_mode_t m, input logic rev_ok);
      logic [15:0] r;
      r = p + s;
      if (m == xyds_pkg::mode_modulo && !s[15] && r > me) begin
         r = r - (me - ms + 16'h0001);
      end else if (m == xyds_pkg::mode_modulo && s[15] && r < ms) begin
         r = r + (me - ms + 16'h0001);
      end else if (m == xyds_pkg::mode_bitrev && rev_ok) begin
         r = rev16(rev16(p) + rev16(x_rev_mod));
      end
      return r;
   endfunction : next_ptr

   function automatic logic [15:0] word_at(input logic [15:0] a);
      return shadow.exists(a[15:1]) ? shadow[a[15:1]] : ({1'b0, a[15:1]} ^ 16'hA55A);
   endfunction : word_at

   task automatic check_word(input string what, input logic [15:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_bit(input string what, input logic exp, got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   // ************************************************************
   // Stimulus
   // ************************************************************
   // Modulo pointers start inside the buffer and step at most one length, so one wrap suffices.
   // Other word pointers are made odd, so the ignored byte select bit is always exercised.
   task automatic pick(input xyds_pkg::xyds_mode_t m, input logic [15:0] ms, me, input logic w,
                       output logic [15:0] p, s);
      if (m == xyds_pkg::mode_modulo) begin
         p = (ms + 16'($urandom_range(0, me - ms))) & 16'hFFFE;
         s = 16'($urandom_range(0, me - ms + 1)) & 16'hFFFE;
      end else begin
         p = 16'($urandom) | {15'h0000, w};
         s = 16'($urandom) & 16'hFFFE;
      end
      if ($urandom_range(0, 1) == 1) begin
         s = -s;
      end
   endtask : pick

   task automatic gen();
      logic [15:0] len;
      op          = xyds_pkg::xyds_op_t'($urandom_range(0, 8));
      x_rd_mode   = xyds_pkg::xyds_mode_t'($urandom_range(0, 2));
      x_wr_mode   = xyds_pkg::xyds_mode_t'($urandom_range(0, 2));
      y_rd_mode   = xyds_pkg::xyds_mode_t'($urandom_range(0, 2));
      x_rd_word   = 1'($urandom);
      x_wr_word   = 1'($urandom);
      x_rev_mod   = 16'($urandom);
      x_wr_data   = 16'($urandom);
      len         = 16'($urandom_range(2, 64)) << 1;
      x_mod_start = 16'h1000 + (16'($urandom_range(0, 2047)) << 1);
      x_mod_end   = x_mod_start + len - 16'h0001;
      y_mod_start = 16'h4000 + (16'($urandom_range(0, 2047)) << 1);
      y_mod_end   = y_mod_start + len - 16'h0001;
      pick(x_rd_mode, x_mod_start, x_mod_end, x_rd_word, x_rd_ptr, x_rd_step);
      pick(x_wr_mode, x_mod_start, x_mod_end, x_wr_word, x_wr_ptr, x_wr_step);
      pick(y_rd_mode, y_mod_start, y_mod_end, 1'b1, y_rd_ptr, y_rd_step);
   endtask : gen

   task automatic run_txn(input logic xr, xw, yr);
      logic [15:0] xea, wea, yea, xexp, yexp, wdat, old;
      logic  [1:0] be;
      logic        yok, yerr;
      xea  = x_rd_word ? (x_rd_ptr & 16'hFFFE) : x_rd_ptr;
      wea  = x_wr_word ? (x_wr_ptr & 16'hFFFE) : x_wr_ptr;
      yea  = y_rd_ptr & 16'hFFFE;
      yok  = yr && op != xyds_pkg::op_general && yea >= YB;
      yerr = yr && op != xyds_pkg::op_general && yea < YB;
      xexp = word_at(xea);
      yexp = word_at(yea);
      old  = word_at(wea);
      wdat = x_wr_word ? x_wr_data : {2{x_wr_data[7:0]}};
      be   = x_wr_word ? xyds_pkg::BE_WORD : (wea[0] ? xyds_pkg::BE_HI : xyds_pkg::BE_LO);
      x_rd_req = xr;
      x_wr_req = xw;
      y_rd_req = yr;
      @(negedge clk);
      x_rd_req = 1'b0;
      x_wr_req = 1'b0;
      y_rd_req = 1'b0;
      check_bit("ram_x_rd_en", xr, ram_x_rd_en);
      if (xr) begin
         check_word("ram_x_rd_addr", xea, ram_x_rd_addr);
         check_word("x_rd_ptr_next", next_ptr(x_rd_ptr, x_rd_step, x_mod_start, x_mod_end, x_rd_mode, 1'b0),
                    x_rd_ptr_next);
      end
      check_bit("ram_x_wr_en", xw, ram_x_wr_en);
      if (xw) begin
         check_word("ram_x_wr_addr", wea, ram_x_wr_addr);
         check_word("ram_x_wr_data", wdat, ram_x_wr_data);
         check_word("ram_x_wr_be", {14'h0000, be}, {14'h0000, ram_x_wr_be});
         check_word("x_wr_ptr_next", next_ptr(x_wr_ptr, x_wr_step, x_mod_start, x_mod_end, x_wr_mode, 1'b1),
                    x_wr_ptr_next);
         shadow[wea[15:1]] = {be[1] ? wdat[15:8] : old[15:8], be[0] ? wdat[7:0] : old[7:0]};
      end
      check_bit("ram_y_rd_en", yok, ram_y_rd_en);
      check_bit("y_range_err", yerr, y_range_err);
      if (yok) begin
         check_word("ram_y_rd_addr", yea, ram_y_rd_addr);
         check_word("y_rd_ptr_next", next_ptr(y_rd_ptr, y_rd_step, y_mod_start, y_mod_end, y_rd_mode, 1'b0),
                    y_rd_ptr_next);
      end
      repeat (2) @(negedge clk);
      check_bit("x_rd_valid", xr, x_rd_valid);
      if (xr) begin
         check_word("x_rd_data", xexp, x_rd_data);
      end
      check_bit("y_rd_valid", yok, y_rd_valid);
      if (yok) begin
         check_word("y_rd_data", yexp, y_rd_data);
      end
   endtask : run_txn

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end

   initial begin
      {clk, rst_b, x_rd_req, x_rd_word, x_wr_req, x_wr_word, y_rd_req} = 7'h00;
      {x_mod_start, x_mod_end, y_mod_start, y_mod_end, x_rev_mod} = 80'h0;
      {x_rd_ptr, x_rd_step, x_wr_ptr, x_wr_step, x_wr_data, y_rd_ptr, y_rd_step} = 112'h0;
      op         = xyds_pkg::op_general;
      x_rd_mode  = xyds_pkg::mode_linear;
      x_wr_mode  = xyds_pkg::mode_linear;
      y_rd_mode  = xyds_pkg::mode_linear;
      fail_count = 0;
      tests_run  = 0;
      cycles     = 0;
      void'($urandom(32'h1E60));
      repeat (2) @(negedge clk);
      check_bit("x_rd_valid", 1'b0, x_rd_valid);
      check_bit("ram_x_wr_en", 1'b0, ram_x_wr_en);
      rst_b = 1'b1;
      for (int i = 0; i < 400; i++) begin
         gen();
         run_txn(1'($urandom), 1'($urandom), 1'($urandom));
      end
      // Every instruction class against a Y read well inside Y space.
      for (int k = 0; k < 9; k++) begin
         gen();
         op        = xyds_pkg::xyds_op_t'(k);
         y_rd_mode = xyds_pkg::mode_linear;
         y_rd_ptr  = 16'h4000;
         run_txn(1'b1, 1'b0, 1'b1);
      end
      // Y reads on both sides of the fixed boundary.
      for (int k = 0; k < 2; k++) begin
         gen();
         op        = xyds_pkg::mac_op;
         y_rd_mode = xyds_pkg::mode_linear;
         y_rd_ptr  = YB - 16'(2 * k);
         run_txn(1'b0, 1'b0, 1'b1);
      end
      // Top of the byte range, odd byte write, then a word written and read back.
      gen();
      {x_rd_word, x_wr_word, x_rd_ptr, x_wr_ptr} = {2'b10, 16'hFFFE, 16'hFFFF};
      run_txn(1'b1, 1'b1, 1'b0);
      gen();
      {x_rd_word, x_wr_word, x_rd_ptr, x_wr_ptr} = {2'b11, 16'h2468, 16'h2468};
      run_txn(1'b0, 1'b1, 1'b0);
      run_txn(1'b1, 1'b0, 1'b0);
      // A second reset in mid-run clears the registered pointers at once.
      rst_b = 1'b0;
      #1;
      check_word("x_wr_ptr_next", xyds_pkg::RST_PTR, x_wr_ptr_next);
      check_word("x_rd_data", xyds_pkg::RST_DATA, x_rd_data);
      check_bit("ram_x_rd_en", 1'b0, ram_x_rd_en);
      @(negedge clk);
      rst_b = 1'b1;
      // The first request after release is taken at the very next edge.
      gen();
      run_txn(1'b1, 1'b1, 1'b1);
      gen();
      run_txn(1'b1, 1'b0, 1'b1);
      wrap_up();
   end
endmodule : test_xyds_top
